// File: core/sbml_top.sv
// sbml_top.sv: boot-mode entry, auto-baud, handshake, flash wipe and RAM download
// assumes: high-voltage detectors give logic levels; flash read data in the same cycle
// as the address; RAM write port accepts one byte per cycle
`include "sbml_params.svh"

//
// Contract
// (RQ1) host holds program voltage and upper mode pin at 12 V for boot
// (RQ2) mode-select bits report mode 2 or 3 while booting
// (RQ3) boot program starts on reset exit, using serial channel 1 asynchronous
// (RQ4) measure nine-bit low period of first frame, load baud divisor
// (RQ5) after alignment transmit one byte H'00 to host
// (RQ6) host checks alignment byte then replies H'55
// (RQ7) on bad alignment byte host resets and restarts boot mode
// (RQ8) host uses 2400, 4800 or 9600 bps within clock ranges
// (RQ9) download 1934 bytes to H'F7E0..H'FF6D then branch to H'F7E0
// (RQ10) loader RAM regions stay reserved until the branch
// (RQ11) receive line high at reset end; wait 100 states before measuring
// (RQ12) any non-erased user-area flash byte triggers erase of all blocks
// (RQ13) software must not rely on interrupts during flash program or erase
// (RQ14) before branch clear serial enables, keep divisor, drive transmit pin high
// (RQ15) user program initialises CPU registers and stack pointer first
// (RQ16) sample upper mode and program voltage pins at reset release, latch boot
// (RQ17) host leaves boot mode by long reset with 12 V removed
// (RQ18) latched boot state survives removal of 12 V without reset
// (RQ19) watchdog reset keeps boot latch, restarts boot program
// (RQ20) host holds external pin settings constant during boot mode
// (RQ21) during reset address ports low only in mode 1; strobes by mode
module sbml_top #(
	parameter int DIV_W = 16,
	parameter int CNT_W = 20
)(
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic        wdtReset,
	input  wire logic        upperModeHv,
	input  wire logic        upper_mode_pin,
	input  wire logic        lower_mode_pin,
	input  wire logic        programVoltageHv,
	input  wire logic        serial_receive_pin,
	output logic             serialTxOut,
	output logic             serialTxOe,
	output logic [15:0]      flashAddr,
	output logic             flashRdEn,
	input  wire logic [7:0]  flashData,
	output logic             eraseAllReq,
	input  wire logic        eraseDone,
	output logic             ramWe,
	output logic [15:0]      ramAddr,
	output logic [7:0]       ramData,
	output logic             loaderAreaLock,
	output logic             branchReq,
	output logic [15:0]      branchAddr,
	output logic             addrPortOut,
	output logic             addrPortOe,
	output logic             address_strobe_out,
	output logic             addressStrobeOe,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata
);
	import sbml_pkg::*;

	initial
	begin
		if (DIV_W < 16 || CNT_W < DIV_W + 4) $error("sbml_top: widths too small");
	end

	function automatic logic [DIV_W-1:0] div9(input logic [CNT_W-1:0] c);
		logic [CNT_W-1:0] q;
		q = (c + CNT_W'(4)) / CNT_W'(`SBML_MEASURE_BITS);
		return q[DIV_W-1:0];
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [3:0] pinMeta_r;
	logic [3:0] pinSync_r;
	logic [2:0] rstMeta_r;
	logic [2:0] rstSync_r;

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pinMeta_r <= `SBML_PIN_RST;
			pinSync_r <= `SBML_PIN_RST;
		end
		else
		begin
			pinMeta_r <= {serial_receive_pin, lower_mode_pin, programVoltageHv, upperModeHv};
			pinSync_r <= pinMeta_r;
		end
	end

	// free-running view of reset and mode pins for the pins during reset
	always_ff @(posedge ref_clk)
	begin
		rstMeta_r <= {rstn, upper_mode_pin, lower_mode_pin};
		rstSync_r <= rstMeta_r;
	end

	wire logic rxS     = pinSync_r[3];
	wire logic lowerS  = pinSync_r[2];
	wire logic vppHvS  = pinSync_r[1];
	wire logic upperHvS = pinSync_r[0];

	// ----------------------------------------------------------------
	// mode latch, taken once after release of the external reset
	// ----------------------------------------------------------------
	logic [1:0]  capCnt_r;
	logic        bootLatch_r;
	sbml_mode_t  modeSel_r;

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			capCnt_r    <= 2'h0;
			bootLatch_r <= 1'b0;
			modeSel_r   <= 2'h0;
		end
		else if (capCnt_r != 2'h3)
		begin
			capCnt_r <= capCnt_r + 2'h1;
			if (capCnt_r == 2'h2)
			begin
				bootLatch_r <= upperHvS && vppHvS; // RQ16 RQ18
				modeSel_r   <= {1'b1, lowerS}; // RQ2
			end
		end
	end

	wire logic modeReady = (capCnt_r == 2'h3);

	// ----------------------------------------------------------------
	// register file and bus
	// ----------------------------------------------------------------
	logic [7:0]       regAddr;
	logic             regMapped;
	logic             regWr;
	logic [31:0]      regWdata;
	logic [31:0]      regRdata;
	logic [DIV_W-1:0] baud_r;
	logic             rxEnBit_r;
	logic             txEnBit_r;
	logic             p8Dir_r;
	logic             p8Dat_r;
	logic             ackErr_r;
	logic             erased_r;
	sbml_state_t      state_r;
	sbml_state_t      state_nxt;

	sbml_ahb u_ahb (
		.ref_clk   (ref_clk),
		.rstn      (rstn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata),
		.regAddr   (regAddr),
		.regMapped (regMapped),
		.regWr     (regWr),
		.regWdata  (regWdata),
		.regRdata  (regRdata)
	);

	wire logic selMode   = regMapped && (regAddr == `SBML_OFS_MODE);
	wire logic selBaud   = regMapped && (regAddr == `SBML_OFS_BAUD);
	wire logic selSerCtl = regMapped && (regAddr == `SBML_OFS_SERCTL);
	wire logic selPort8  = regMapped && (regAddr == `SBML_OFS_PORT8);
	wire logic selStatus = regMapped && (regAddr == `SBML_OFS_STATUS);

	wire logic [31:0] rdMode = (32'(bootLatch_r) << `SBML_MODE_BOOT_BIT) | 32'(modeSel_r);
	wire logic [31:0] rdSer  = (32'(txEnBit_r) << `SBML_SER_TE_BIT)
	                         | (32'(rxEnBit_r) << `SBML_SER_RE_BIT);
	wire logic [31:0] rdP8   = (32'(p8Dat_r) << `SBML_P8_DAT_BIT)
	                         | (32'(p8Dir_r) << `SBML_P8_DIR_BIT);
	wire logic [31:0] rdStat = (32'(ackErr_r) << `SBML_ST_ACKERR_BIT)
	                         | (32'(erased_r) << `SBML_ST_ERASED_BIT) | 32'(state_r);

	assign regRdata = selMode   ? rdMode :
	                  selBaud   ? 32'(baud_r) :
	                  selSerCtl ? rdSer :
	                  selPort8  ? rdP8 :
	                  selStatus ? rdStat : 32'h00000000;

	// ----------------------------------------------------------------
	// serial channel 1
	// ----------------------------------------------------------------
	logic       txGo_r;
	logic       txBusy;
	logic       txLine;
	logic       rxValid;
	logic [7:0] rxByte;

	sbml_uart #(.DIV_W(DIV_W)) u_uart (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.bitDiv  (baud_r),
		.txEn    (txEnBit_r),
		.rxEn    (rxEnBit_r),
		.txGo    (txGo_r),
		.txByte  (`SBML_ALIGN_BYTE), // RQ5
		.txBusy  (txBusy),
		.txLine  (txLine),
		.rxLine  (rxS),
		.rxValid (rxValid),
		.rxByte  (rxByte)
	);

	// ----------------------------------------------------------------
	// boot sequence
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] cnt_r;
	logic [15:0]      fAddr_r;
	logic             fPend_r;
	logic [15:0]      lAddr_r;

	wire logic [15:0] flashEnd = modeSel_r[0] ? `SBML_FLASH_END_M3 : `SBML_FLASH_END_M2; // RQ12
	wire logic        dirty    = fPend_r && (flashData != `SBML_ERASED_BYTE);
	wire logic        lastRd   = fPend_r && (fAddr_r == flashEnd);
	wire logic        lastLd   = (lAddr_r == `SBML_USER_END);

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:    state_nxt = ST_IDLE;
			ST_SETTLE:  if (cnt_r == CNT_W'(`SBML_SETTLE_CYC - 1)) state_nxt = ST_WAITHI; // RQ11
			ST_WAITHI:  if (rxS) state_nxt = ST_WAITLO; // RQ11
			ST_WAITLO:  if (!rxS) state_nxt = ST_MEASURE;
			ST_MEASURE: if (rxS) state_nxt = ST_SENDACK;
			ST_SENDACK: if (txGo_r) state_nxt = ST_WAITREP;
			ST_WAITREP: if (rxValid && rxByte == `SBML_REPLY_BYTE) state_nxt = ST_BLANK;
			ST_BLANK:   if (dirty) state_nxt = ST_ERASE;
			            else if (lastRd) state_nxt = ST_LOAD;
			ST_ERASE:   if (eraseDone) state_nxt = ST_LOAD;
			ST_LOAD:    if (rxValid && lastLd) state_nxt = ST_BRANCH; // RQ9
			ST_BRANCH:  state_nxt = ST_DONE;
			ST_DONE:    state_nxt = ST_DONE;
			default:    state_nxt = ST_IDLE;
		endcase
		if (!modeReady)
			state_nxt = ST_SETTLE;
		else if (state_r == ST_SETTLE && !bootLatch_r)
			state_nxt = ST_IDLE;
		if (wdtReset && bootLatch_r)
			state_nxt = ST_SETTLE; // RQ19
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_r <= ST_SETTLE;
			cnt_r   <= '0;
			fAddr_r <= 16'h0000;
			fPend_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			if (state_nxt != state_r)
				cnt_r <= '0;
			else
				cnt_r <= cnt_r + CNT_W'(1);
			fPend_r <= (state_r == ST_BLANK) && (state_nxt == ST_BLANK) && !fPend_r;
			if (state_r != ST_BLANK)
				fAddr_r <= 16'h0000;
			else if (fPend_r)
				fAddr_r <= fAddr_r + 16'h0001;
		end
	end

	// serial setup, download and hand-over
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			baud_r    <= `SBML_BAUD_RST;
			rxEnBit_r <= 1'b0;
			txEnBit_r <= 1'b0;
			p8Dir_r   <= 1'b0;
			p8Dat_r   <= 1'b0;
			txGo_r    <= 1'b0;
			ackErr_r  <= 1'b0;
			erased_r  <= 1'b0;
			lAddr_r   <= `SBML_USER_START;
		end
		else if (wdtReset && bootLatch_r)
		begin
			baud_r    <= `SBML_BAUD_RST;
			rxEnBit_r <= 1'b0;
			txEnBit_r <= 1'b0;
			p8Dir_r   <= 1'b0;
			p8Dat_r   <= 1'b0;
			txGo_r    <= 1'b0;
			lAddr_r   <= `SBML_USER_START;
		end
		else
		begin
			txGo_r <= (state_nxt == ST_SENDACK) && !txGo_r && !txBusy; // RQ5
			if (state_r == ST_MEASURE && rxS)
			begin
				baud_r    <= div9(cnt_r); // RQ4
				rxEnBit_r <= 1'b1; // RQ3
				txEnBit_r <= 1'b1; // RQ3
			end
			else if (state_r == ST_BRANCH)
			begin
				rxEnBit_r <= 1'b0; // RQ14
				txEnBit_r <= 1'b0; // RQ14
				p8Dir_r   <= 1'b1; // RQ14
				p8Dat_r   <= 1'b1; // RQ14
			end
			else if (regWr)
			begin
				if (selBaud)
					baud_r <= regWdata[DIV_W-1:0];
				if (selSerCtl)
				begin
					rxEnBit_r <= regWdata[`SBML_SER_RE_BIT];
					txEnBit_r <= regWdata[`SBML_SER_TE_BIT];
				end
				if (selPort8)
				begin
					p8Dir_r <= regWdata[`SBML_P8_DIR_BIT];
					p8Dat_r <= regWdata[`SBML_P8_DAT_BIT];
				end
			end
			if (state_r == ST_WAITREP && rxValid && rxByte != `SBML_REPLY_BYTE)
				ackErr_r <= 1'b1;
			if (state_r == ST_ERASE && eraseDone)
				erased_r <= 1'b1;
			if (state_r == ST_LOAD && rxValid && !lastLd)
				lAddr_r <= lAddr_r + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			serialTxOut    <= 1'b1;
			serialTxOe     <= 1'b0;
			flashAddr      <= 16'h0000;
			flashRdEn      <= 1'b0;
			eraseAllReq    <= 1'b0;
			ramWe          <= 1'b0;
			ramAddr        <= 16'h0000;
			ramData        <= 8'h00;
			loaderAreaLock <= 1'b0;
			branchReq      <= 1'b0;
			branchAddr     <= 16'h0000;
		end
		else
		begin
			serialTxOut <= txEnBit_r ? txLine : p8Dat_r;
			serialTxOe  <= txEnBit_r || p8Dir_r;
			flashAddr   <= fAddr_r;
			flashRdEn   <= (state_r == ST_BLANK) && !fPend_r;
			eraseAllReq <= (state_nxt == ST_ERASE); // RQ12
			ramWe       <= (state_r == ST_LOAD) && rxValid; // RQ9
			ramAddr     <= lAddr_r;
			ramData     <= rxByte;
			// loader scratch areas held until the branch
			loaderAreaLock <= bootLatch_r && (state_nxt != ST_DONE) && (state_nxt != ST_IDLE); // RQ10
			branchReq   <= (state_nxt == ST_DONE) && bootLatch_r; // RQ9
			branchAddr  <= `SBML_USER_START; // RQ9
		end
	end

	// pins during reset, driven from the free-running view
	wire logic inReset = !rstSync_r[2];
	wire logic mode1   = !rstSync_r[1] && rstSync_r[0];
	wire logic mode2   = rstSync_r[1] && !rstSync_r[0];

	always_ff @(posedge ref_clk)
	begin
		addrPortOut        <= 1'b0;
		addrPortOe         <= inReset && mode1; // RQ21
		address_strobe_out <= 1'b1;
		addressStrobeOe    <= inReset && (mode1 || mode2); // RQ21
	end

endmodule

// File: core/sbml_params.svh
// sbml_params.svh: offsets, field positions, reset values and counts of the boot loader
// assumes: included by the package and every design file of the block
`ifndef SBML_PARAMS_SVH
`define SBML_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define SBML_OFS_MODE      8'h00
`define SBML_OFS_BAUD      8'h04
`define SBML_OFS_SERCTL    8'h08
`define SBML_OFS_PORT8     8'h0C
`define SBML_OFS_STATUS    8'h10

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SBML_MODE_LOWER_BIT  0
`define SBML_MODE_UPPER_BIT  1
`define SBML_MODE_BOOT_BIT   7
`define SBML_SER_RE_BIT      4
`define SBML_SER_TE_BIT      5
`define SBML_P8_DIR_BIT      0
`define SBML_P8_DAT_BIT      1
`define SBML_ST_ACKERR_BIT   7
`define SBML_ST_ERASED_BIT   6

// ----------------------------------------------------------------
// reset values and protocol constants
// ----------------------------------------------------------------
`define SBML_BAUD_RST      16'h0001
`define SBML_PIN_RST       4'h8
`define SBML_ALIGN_BYTE    8'h00
`define SBML_REPLY_BYTE    8'h55
`define SBML_ERASED_BYTE   8'hFF
`define SBML_MEASURE_BITS  20'd9
`define SBML_SETTLE_STATES 100
`define SBML_SETTLE_CYC    (`SBML_SETTLE_STATES)

// ----------------------------------------------------------------
// memory map of the loader
// ----------------------------------------------------------------
`define SBML_USER_START    16'hF7E0
`define SBML_USER_END      16'hFF6D
`define SBML_USER_BYTES    1934
`define SBML_FLASH_END_M2  16'hEF7F
`define SBML_FLASH_END_M3  16'hF77F

`endif

// File: core/sbml_pkg.sv
// sbml_pkg.sv: types of the serial boot mode loader
// assumes: sbml_params.svh on the include path
`include "sbml_params.svh"

package sbml_pkg;

	// boot sequence, gray coded along the usual path
	typedef enum logic [3:0]
	{
		ST_SETTLE  = 4'h0,
		ST_WAITHI  = 4'h1,
		ST_WAITLO  = 4'h3,
		ST_MEASURE = 4'h2,
		ST_SENDACK = 4'h6,
		ST_WAITREP = 4'h7,
		ST_BLANK   = 4'h5,
		ST_ERASE   = 4'h4,
		ST_LOAD    = 4'hC,
		ST_BRANCH  = 4'hD,
		ST_DONE    = 4'hF,
		ST_IDLE    = 4'hE
	} sbml_state_t;

	// operating mode as seen on the mode pins
	typedef logic [1:0] sbml_mode_t;

endpackage

// File: core/sbml_uart.sv
// sbml_uart.sv: 8N1 transmitter and receiver of serial channel 1
// assumes: rxLine already synchronised; bitDiv is cycles per bit, at least 2
`include "sbml_params.svh"

module sbml_uart #(
	parameter int DIV_W = 16
)(
	input  wire logic             ref_clk,
	input  wire logic             rstn,
	input  wire logic [DIV_W-1:0] bitDiv,
	input  wire logic             txEn,
	input  wire logic             rxEn,
	input  wire logic             txGo,
	input  wire logic [7:0]       txByte,
	output logic                  txBusy,
	output logic                  txLine,
	input  wire logic             rxLine,
	output logic                  rxValid,
	output logic [7:0]            rxByte
);
	import sbml_pkg::*;

	initial
	begin
		if (DIV_W < 2) $error("sbml_uart: DIV_W too small");
	end

	logic [9:0]       txSh_r;
	logic [3:0]       txBits_r;
	logic [DIV_W-1:0] txCnt_r;
	logic [8:0]       rxSh_r;
	logic [3:0]       rxBits_r;
	logic [DIV_W-1:0] rxCnt_r;
	logic             rxPrev_r;
	logic             rxValid_r;
	logic [7:0]       rxByte_r;

	wire logic [DIV_W-1:0] divLast = bitDiv - DIV_W'(1);
	wire logic             rxStart = rxEn && (rxBits_r == 4'h0) && rxPrev_r && !rxLine;

	assign txBusy  = (txBits_r != 4'h0);
	assign txLine  = txSh_r[0];
	assign rxValid = rxValid_r;
	assign rxByte  = rxByte_r;

	// ----------------------------------------------------------------
	// transmitter: start bit, eight data bits lsb first, stop bit
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			txSh_r   <= 10'h3FF;
			txBits_r <= 4'h0;
			txCnt_r  <= '0;
		end
		else if (!txEn)
		begin
			txSh_r   <= 10'h3FF;
			txBits_r <= 4'h0;
		end
		else if (txGo && !txBusy)
		begin
			txSh_r   <= {1'b1, txByte, 1'b0};
			txBits_r <= 4'hA;
			txCnt_r  <= divLast;
		end
		else if (txBusy)
		begin
			if (txCnt_r == '0)
			begin
				txSh_r   <= {1'b1, txSh_r[9:1]};
				txBits_r <= txBits_r - 4'h1;
				txCnt_r  <= divLast;
			end
			else
				txCnt_r <= txCnt_r - DIV_W'(1);
		end
	end

	// ----------------------------------------------------------------
	// receiver: samples mid-bit, drops frames whose stop bit is low
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rxSh_r    <= '0;
			rxBits_r  <= 4'h0;
			rxCnt_r   <= '0;
			rxPrev_r  <= 1'b1;
			rxValid_r <= 1'b0;
			rxByte_r  <= 8'h00;
		end
		else
		begin
			rxPrev_r  <= rxLine;
			rxValid_r <= 1'b0;
			if (!rxEn)
				rxBits_r <= 4'h0;
			else if (rxStart)
			begin
				rxBits_r <= 4'hA;
				rxCnt_r  <= bitDiv >> 1;
			end
			else if (rxBits_r != 4'h0)
			begin
				if (rxCnt_r == '0)
				begin
					rxCnt_r  <= divLast;
					rxBits_r <= rxBits_r - 4'h1;
					rxSh_r   <= {rxLine, rxSh_r[8:1]};
					if (rxBits_r == 4'h1)
					begin
						rxValid_r <= rxLine;
						rxByte_r  <= rxSh_r[8:1];
					end
				end
				else
					rxCnt_r <= rxCnt_r - DIV_W'(1);
			end
		end
	end

endmodule

// File: core/sbml_ahb.sv
// sbml_ahb.sv: AHB-Lite slave front end, one wait state per transfer
// assumes: the register file answers regRdata combinationally from regAddr
`include "sbml_params.svh"

module sbml_ahb (
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	output logic [7:0]       regAddr,
	output logic             regMapped,
	output logic             regWr,
	output logic [31:0]      regWdata,
	input  wire logic [31:0] regRdata
);
	import sbml_pkg::*;

	logic        phase_r;
	logic        write_r;
	logic        ready_r;
	logic        mapped_r;
	logic [7:0]  addr_r;
	logic [31:0] rdata_r;
	logic        wr_r;
	logic [31:0] wdata_r;

	// only whole-word transfers write; others complete without effect
	wire logic take = !phase_r && hready && hsel && htrans[1];
	wire logic word = (hsize == 3'h2);
	wire logic inMap = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);

	assign hreadyout = ready_r;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_r;
	assign regAddr   = addr_r;
	assign regMapped = mapped_r;
	assign regWr     = wr_r;
	assign regWdata  = wdata_r;

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			phase_r  <= 1'b0;
			write_r  <= 1'b0;
			ready_r  <= 1'b1;
			mapped_r <= 1'b0;
			addr_r   <= 8'h00;
			rdata_r  <= 32'h00000000;
			wr_r     <= 1'b0;
			wdata_r  <= 32'h00000000;
		end
		else
		begin
			wr_r <= 1'b0;
			if (take)
			begin
				phase_r  <= 1'b1;
				ready_r  <= 1'b0;
				addr_r   <= haddr[7:0];
				mapped_r <= inMap;
				write_r  <= hwrite && word;
			end
			else if (phase_r)
			begin
				phase_r <= 1'b0;
				ready_r <= 1'b1;
				rdata_r <= write_r ? 32'h00000000 : regRdata;
				wr_r    <= write_r && mapped_r;
				wdata_r <= hwdata;
			end
		end
	end

endmodule

// File: bench/sbml_top_sva.sv
// sbml_top_sva.sv: port checks of the boot loader
// assumes: bound into sbml_top, one clock domain
module sbml_top_sva (
	input wire logic        ref_clk,
	input wire logic        rstn,
	input wire logic        wdtReset,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        eraseAllReq,
	input wire logic        eraseDone,
	input wire logic        ramWe,
	input wire logic [15:0] ramAddr,
	input wire logic        loaderAreaLock,
	input wire logic        branchReq,
	input wire logic [15:0] branchAddr,
	input wire logic        serialTxOut,
	input wire logic        serialTxOe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);
	// ------------------------------------------------
	// assertions
	// ------------------------------------------------
	bus_wait_a: assert property (hsel && htrans[1] && hreadyout |=> !hreadyout ##1 hreadyout)
		else $error("bus data phase not one wait state");
	bus_okay_a: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	ram_window_a: assert property (ramWe |-> ramAddr >= 16'hF7E0 && ramAddr <= 16'hFF6D)
		else $error("ram write outside user area");
	area_lock_a: assert property (ramWe |-> loaderAreaLock)
		else $error("ram written without area lock");
	erase_hold_a: assert property (eraseAllReq && !eraseDone |=> eraseAllReq)
		else $error("erase request dropped early");
	erase_quiet_a: assert property (eraseAllReq |-> !ramWe)
		else $error("ram written during erase");
	branch_stay_a: assert property (branchReq && !wdtReset
		|=> branchReq && $stable(branchAddr))
		else $error("branch request not held");
	branch_addr_a: assert property ($rose(branchReq) |-> branchAddr == 16'hF7E0 && !ramWe)
		else $error("branch target wrong");
	tx_idle_a: assert property (branchReq |-> serialTxOut && serialTxOe)
		else $error("transmit pin not driven high");
	cover property (eraseAllReq && eraseDone);
	cover property (ramWe && ramAddr == 16'hFF6D);
	cover property ($rose(branchReq));
endmodule

bind sbml_top sbml_top_sva chk (.*);

// File: bench/sbml_host.sv
// sbml_host.sv: host machine on the far side of serial channel 1
// assumes: bit time in system clocks; transmit line pulled up when released
module sbml_host #(
	parameter int BIT = 4
)(
	input  wire logic ref_clk,
	output logic      rxLine,
	input  wire logic txLine
);
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------
	// 8N1 frames, lsb first
	// ------------------------------------------------
	initial rxLine = 1'b1;
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
			repeat (BIT) @(posedge ref_clk) rxLine <= f[i];
	endtask
	task automatic recv(output logic [7:0] b, output bit ok);
		ok = 1'b0;
		for (int n = 0; n < 5000 && !ok; n++)
		begin
			@(posedge ref_clk);
			ok = (txLine === 1'b0);
		end
		repeat (BIT / 2) @(posedge ref_clk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT) @(posedge ref_clk);
			b[i] = txLine;
		end
	endtask
endmodule

// File: bench/serial_boot_mode_loader_bench.sv
// serial_boot_mode_loader_bench.sv: self-checking bench of the boot loader
// assumes: sbml_host and sbml_top_sva compiled before
module serial_boot_mode_loader_bench;
	import sbml_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        ref_clk = 1'b0, rstn = 1'b0, eraseDone = 1'b0;
	logic        wdtReset = 1'b0, upper_mode_pin = 1'b1;
	logic        upperModeHv = 1'b1, programVoltageHv = 1'b1, lower_mode_pin = 1'b0;
	logic [1:0]  htrans = 2'b00;
	logic        hwrite = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
	logic        serial_receive_pin, serialTxOut, serialTxOe, hreadyout, ramWe, branchReq;
	logic        eraseAllReq;
	logic [15:0] flashAddr, ramAddr, branchAddr;
	logic [7:0]  flashData, ramData, b;
	logic [23:0] q[$];
	logic [31:0] seed = 32'h53B0;
	int          nErrors = 0, checks = 0;
	bit          ok;
	wire         txWire = serialTxOe ? serialTxOut : 1'b1;
	assign flashData = (flashAddr == 16'h0003) ? 8'h5A : 8'hFF;
	always #5 ref_clk = ~ref_clk;
	sbml_top DUT (.*, .hsel(1'b1), .hsize(3'b010),
		.hready(hreadyout), .flashRdEn(), .loaderAreaLock(), .addrPortOut(), .addrPortOe(),
		.address_strobe_out(), .addressStrobeOe(), .hresp());
	sbml_host #(.BIT(4)) host (.ref_clk(ref_clk), .rxLine(serial_receive_pin), .txLine(txWire));
	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic wrapUp();
		$display("checks %0d mismatches %0d", checks, nErrors);
		if (nErrors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			nErrors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic hang(input string nm);
		check({nm, " wait"}, 32'h0, 32'h1);
		wrapUp();
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++n < 50);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++n < 50);
		if (n >= 50)
			hang("bus");
		rd = hrdata;
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check($sformatf("reg %h", a), rd, exp);
	endtask
	// ------------------------------------------------
	// ram write monitor
	// ------------------------------------------------
	always @(posedge ref_clk)
		if (rstn && ramWe === 1'b1)
		begin
			if (q.size() == 0)
				check("spare ram write", 32'h1, 32'h0);
			else
				check("ram write", {8'h0, ramAddr, ramData}, {8'h0, q.pop_front()});
		end
	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial
	begin
		repeat (3) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (10) @(posedge ref_clk);
		rdChk(8'h04, 32'h1);
		rdChk(8'h00, 32'h82);
		bus(1'b1, 8'h14, 32'hFFFF_FFFF);
		rdChk(8'h14, 32'h0);
		$display("entry test done");
		repeat (100) @(posedge ref_clk);
		fork
			host.send(8'h00);
			host.recv(b, ok);
		join
		check("align byte", {23'h0, !ok, b}, 32'h0);
		rdChk(8'h04, 32'h4);
		upperModeHv <= 1'b0;
		upper_mode_pin <= 1'b0;
		host.send(8'h55);
		for (int n = 0; eraseAllReq !== 1'b1; n++)
			if (n > 500) hang("erase"); else @(posedge ref_clk);
		repeat (20) @(posedge ref_clk);
		eraseDone <= 1'b1;
		@(posedge ref_clk);
		eraseDone <= 1'b0;
		repeat (5) @(posedge ref_clk);
		$display("align test done");
		for (int i = 0; i < 1934; i++)
		begin
			b = rnd();
			q.push_back({16'hF7E0 + i[15:0], b});
			host.send(b);
		end
		for (int n = 0; branchReq !== 1'b1; n++)
			if (n > 500) hang("branch"); else @(posedge ref_clk);
		@(posedge ref_clk);
		check("left over", q.size(), 32'h0);
		check("branch", {16'h0, branchAddr}, 32'hF7E0);
		check("tx pin", {30'h0, serialTxOe, serialTxOut}, 32'h3);
		rdChk(8'h08, 32'h0);
		rdChk(8'h0C, 32'h3);
		rdChk(8'h04, 32'h4);
		rdChk(8'h00, 32'h82);
		bus(1'b0, 8'h10, 32'h0);
		check("erased", {30'h0, rd[7:6]}, 32'h1);
		$display("download test done");
		wdtReset <= 1'b1;
		@(posedge ref_clk);
		wdtReset <= 1'b0;
		rdChk(8'h04, 32'h1);
		rdChk(8'h10, 32'h40);
		rdChk(8'h00, 32'h82);
		rstn <= 1'b0;
		programVoltageHv <= 1'b0;
		repeat (10) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (10) @(posedge ref_clk);
		rdChk(8'h00, 32'h2);
		rdChk(8'h10, 32'hE);
		$display("restart test done");
		wrapUp();
	end
endmodule
